//--- core/led_strap_pin.sv
`timescale 1ns/1ps
`default_nettype none

// One dual-purpose pin: strap input while sampling, status output after.
module led_strap_pin (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Control from the phase logic, plus the status level to drive
   input wire logic capture,
   input wire logic drive_en,
   input wire logic status_in,
   // Pin
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe,
   // Latched strap level
   output logic strap
);

   logic pin_out_r;
   logic pin_oe_r;
   logic strap_r;

   // The strap level is caught on the capture pulse only, never under reset.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pin_out_r <= 1'b0;
         pin_oe_r <= 1'b0;
         strap_r <= 1'b0;
      end else begin
         pin_out_r <= drive_en & status_in;
         pin_oe_r <= drive_en;
         if (capture) begin
            strap_r <= pin_in;
         end
      end
   end

   assign pin_out = pin_out_r;
   assign pin_oe = pin_oe_r;
   assign strap = strap_r;

endmodule // led_strap_pin

`default_nettype wire

//--- core/strap_latch_and_led_status.sv
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module strap_latch_and_led_status
   import strap_pkg::*;
#(
   parameter int NCH = CHANNELS,
   parameter int SETTLE = SETTLE_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Status from the channel datapaths
   input wire logic [NCH-1:0] rx_activity,
   input wire logic [NCH-1:0] collision,
   input wire logic [NCH-1:0] link_good,
   // Receive activity pins, fiber strap while sampling
   input wire logic [NCH-1:0] receive_activity_led_in,
   output logic [NCH-1:0] receive_activity_led_out,
   output logic [NCH-1:0] receive_activity_led_oe,
   // Collision pins, output only
   output logic [NCH-1:0] collision_led,
   // Link pins, address and link pulse straps while sampling
   input wire logic [NCH-1:0] link_good_led_in,
   output logic [NCH-1:0] link_good_led_out,
   output logic [NCH-1:0] link_good_led_oe,
   // Resulting configuration
   output logic [NCH-1:0] fiber_mode,
   output logic [PHY_ADDR_BITS-1:0] phy_address_strap,
   output logic link_pulse_disable,
   output logic straps_done
);

   ////////////////////////////////////////////////////////////////////////////
   // Strap phase sequencing.

   phase_t phase_r;
   phase_t phase_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic capture_w;
   logic run_w;

   // The pins float as inputs for a settle time so board straps win.
   assign run_w = (phase_r == PH_RUN);
   assign capture_w = (phase_r == PH_SAMPLE) &&
      (cnt_r == CNT_W'(SETTLE - 1));
   assign cnt_nxt = capture_w ? cnt_r : cnt_r + CNT_W'(1);

   always_comb begin
      phase_nxt = phase_r;
      case (phase_r)
         PH_SAMPLE: begin
            if (capture_w) begin
               phase_nxt = PH_RUN;
            end
         end
         default: begin
            phase_nxt = PH_RUN;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         phase_r <= PH_SAMPLE;
         cnt_r <= '0;
      end else if (!run_w) begin
         phase_r <= phase_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Dual-purpose pins.

   logic [NCH-1:0] fiber_strap_w;
   logic [NCH-1:0] link_strap_w;

   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_pin
         led_strap_pin u_rx (
            .core_clk(core_clk),
            .rst(rst),
            .capture(capture_w),
            .drive_en(run_w),
            .status_in(rx_activity[gi]),
            .pin_in(receive_activity_led_in[gi]),
            .pin_out(receive_activity_led_out[gi]),
            .pin_oe(receive_activity_led_oe[gi]),
            .strap(fiber_strap_w[gi])
         );
         led_strap_pin u_link (
            .core_clk(core_clk),
            .rst(rst),
            .capture(capture_w),
            .drive_en(run_w),
            .status_in(link_good[gi]),
            .pin_in(link_good_led_in[gi]),
            .pin_out(link_good_led_out[gi]),
            .pin_oe(link_good_led_oe[gi]),
            .strap(link_strap_w[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Control registers and Avalon-MM slave.

   logic [NCH-1:0] fiber_ctrl_r;
   logic link_ctrl_r;
   logic waitrequest_r;
   logic [31:0] readdata_r;
   logic [31:0] status_w;
   logic [31:0] raw_w;
   logic [31:0] rdmux_w;
   logic wr_fire_w;
   logic rd_take_w;

   // Every access costs one wait cycle; writes land when waitrequest is low.
   assign wr_fire_w = write && !waitrequest_r && byteenable[0];
   assign rd_take_w = read && waitrequest_r;

   assign status_w = {23'h0, run_w, link_pulse_disable,
                      phy_address_strap, fiber_mode};
   assign raw_w = {27'h0, link_strap_w[0], fiber_strap_w};

   // Unmapped offsets read as zero and ignore writes.
   assign rdmux_w = (address == FIBER_CTRL_OFS) ? {28'h0, fiber_ctrl_r} :
                    (address == LINK_CTRL_OFS) ? {31'h0, link_ctrl_r} :
                    (address == STATUS_OFS) ? status_w :
                    (address == STRAP_RAW_OFS) ? raw_w :
                    32'h0;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         waitrequest_r <= 1'b1;
         readdata_r <= 32'h0;
      end else begin
         waitrequest_r <= !((read || write) && waitrequest_r);
         if (rd_take_w) begin
            readdata_r <= rdmux_w;
         end
      end
   end

   // Control bits steer the effective fiber and link pulse settings.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         fiber_ctrl_r <= FIBER_CTRL_RST;
         link_ctrl_r <= LINK_CTRL_RST;
      end else if (wr_fire_w) begin
         if (address == FIBER_CTRL_OFS) begin
            fiber_ctrl_r <= writedata[NCH-1:0];
         end else if (address == LINK_CTRL_OFS) begin
            link_ctrl_r <= writedata[0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration and collision outputs.

   logic [NCH-1:0] fiber_mode_r;
   logic [PHY_ADDR_BITS-1:0] phy_r;
   logic lp_dis_r;
   logic [NCH-1:0] col_r;
   logic done_r;

   // Straps are zero until captured, so no stale pin level leaks out.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         fiber_mode_r <= '0;
         phy_r <= '0;
         lp_dis_r <= 1'b0;
         col_r <= '0;
         done_r <= 1'b0;
      end else begin
         fiber_mode_r <= fiber_strap_w | fiber_ctrl_r;
         phy_r <= link_strap_w[3:1];
         // link pulse OR control, default enabled
         lp_dis_r <= link_strap_w[0] | link_ctrl_r;
         col_r <= collision;
         done_r <= run_w;
      end
   end

   assign fiber_mode = fiber_mode_r;
   assign phy_address_strap = phy_r;
   assign link_pulse_disable = lp_dis_r;
   assign collision_led = col_r;
   assign straps_done = done_r;
   assign waitrequest = waitrequest_r;
   assign readdata = readdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   fiber_capture_a: assert property (
      @(posedge core_clk) disable iff (rst)
      $rose(run_w) |-> fiber_strap_w == $past(receive_activity_led_in))
      else $error("fiber strap not taken from receive pins");

   fiber_or_a: assert property (
      @(posedge core_clk) disable iff (rst)
      run_w && $past(run_w) |=> fiber_mode == ($past(fiber_ctrl_r) |
      $past(fiber_strap_w)))
      else $error("fiber mode is not strap OR control");

   rx_drive_a: assert property (
      @(posedge core_clk) disable iff (rst)
      run_w |=> receive_activity_led_oe == '1 &&
      receive_activity_led_out == $past(rx_activity))
      else $error("receive pins not showing activity");

   // The edge just after reset shows the cleared flop, not the input.
   collision_a: assert property (
      @(posedge core_clk) disable iff (rst)
      !$past(rst) |-> collision_led == $past(collision))
      else $error("collision output does not follow collisions");

   link_drive_a: assert property (
      @(posedge core_clk) disable iff (rst)
      run_w |=> link_good_led_oe == '1 &&
      link_good_led_out == $past(link_good))
      else $error("link pins not showing link status");

   phy_addr_a: assert property (
      @(posedge core_clk) disable iff (rst)
      $rose(run_w) |=> phy_address_strap == $past(link_good_led_in[3:1], 2))
      else $error("address bits not from link pins D C B");

   lp_or_a: assert property (
      @(posedge core_clk) disable iff (rst)
      run_w && (link_strap_w[0] || link_ctrl_r) |=> link_pulse_disable)
      else $error("link pulse disable not set by strap or control");

   lp_default_a: assert property (
      @(posedge core_clk) disable iff (rst)
      !link_strap_w[0] && !link_ctrl_r |=> !link_pulse_disable)
      else $error("link pulses disabled without cause");

   strap_hold_a: assert property (
      @(posedge core_clk) disable iff (rst)
      run_w |=> $stable(fiber_strap_w) && $stable(link_strap_w) && run_w)
      else $error("strap changed after capture");

   sample_float_a: assert property (
      @(posedge core_clk) disable iff (rst)
      !run_w && !$past(run_w) |-> link_good_led_oe == '0 &&
      receive_activity_led_oe == '0)
      else $error("strap pins driven while sampling");

endmodule // strap_latch_and_led_status

`default_nettype wire

//--- core/strap_pkg.sv
package strap_pkg;

   // Channel and address widths.
   localparam int CHANNELS = 4;
   localparam int PHY_ADDR_BITS = 3;

   // Strap settle time after reset release, in its own unit.
   localparam int STRAP_SETTLE_NS = 1000;
   localparam int CLK_PERIOD_NS = 100;
   // Least time, so round up to whole cycles.
   localparam int SETTLE_CYCLES =
      (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;

   // Register byte offsets on the Avalon-MM slave.
   localparam logic [3:0] FIBER_CTRL_OFS = 4'h0;
   localparam logic [3:0] LINK_CTRL_OFS = 4'h4;
   localparam logic [3:0] STATUS_OFS = 4'h8;
   localparam logic [3:0] STRAP_RAW_OFS = 4'hC;

   // Reset values of the writable control bits.
   localparam logic [3:0] FIBER_CTRL_RST = 4'h0;
   localparam logic LINK_CTRL_RST = 1'b0;

   // Field positions in the status register.
   localparam int ST_FIBER_LSB = 0;
   localparam int ST_PHY_LSB = 4;
   localparam int ST_LP_BIT = 7;
   localparam int ST_RUN_BIT = 8;
   // Field position in the raw strap register.
   localparam int RAW_LP_BIT = 4;

   // Strap phase of the pins.
   typedef enum logic {PH_SAMPLE, PH_RUN} phase_t;

endpackage

//--- test/strap_board.sv
`timescale 1ns/1ps
`default_nettype none

// Board side of the pins: strap resistors plus the LED buffer inputs.
module strap_board (
   // Strap resistor levels chosen by the bench
   input wire logic [3:0] rx_strap,
   input wire logic [3:0] lk_strap,
   // Pin drive from the device
   input wire logic [3:0] rx_out,
   input wire logic [3:0] rx_oe,
   input wire logic [3:0] lk_out,
   input wire logic [3:0] lk_oe,
   // Resolved pin levels
   output logic [3:0] rx_pin,
   output logic [3:0] lk_pin
);
   // Every pin carries a resistor, so a released pin falls to its strap
   // level rather than holding the last driven value.
   assign rx_pin = (rx_oe & rx_out) | (~rx_oe & rx_strap);
   assign lk_pin = (lk_oe & lk_out) | (~lk_oe & lk_strap);
endmodule // strap_board

`default_nettype wire

//--- test/strap_latch_and_led_status_bench.sv
`timescale 1ns/1ps
`default_nettype none

module strap_latch_and_led_status_bench
   import strap_pkg::*;
;
   // Short settle keeps each reset cheap in simulation.
   localparam int SET = 2;
   // Bound on any single wait, far above any legal answer time.
   localparam int WAIT_MAX = 50;
   // Bound on the whole run, in clock cycles.
   localparam int RUN_MAX = 20000;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [3:0] byteenable = 4'hF;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest;
   logic [3:0] rx_activity = 4'h0;
   logic [3:0] collision = 4'h0;
   logic [3:0] link_good = 4'h0;
   logic [3:0] rx_strap = 4'h0;
   logic [3:0] lk_strap = 4'h0;
   logic [3:0] rx_pin, rx_out, rx_oe, col_led, lk_pin, lk_out, lk_oe, fiber;
   logic [2:0] phy;
   logic lp, done;
   int mismatches = 0;
   int tests_run = 0;

   ////////////////////////////////////////////////////////////////////////
   // The clock toggles every half period of 100 ns.
   always #50 core_clk = ~core_clk;

   ////////////////////////////////////////////////////////////////////////
   // Device under test.
   strap_latch_and_led_status #(
      .NCH(4),
      .SETTLE(SET)
   ) dut_u (
      .core_clk(core_clk),
      .rst(rst),
      .address(address),
      .read(read),
      .write(write),
      .byteenable(byteenable),
      .writedata(writedata),
      .readdata(readdata),
      .waitrequest(waitrequest),
      .rx_activity(rx_activity),
      .collision(collision),
      .link_good(link_good),
      .receive_activity_led_in(rx_pin),
      .receive_activity_led_out(rx_out),
      .receive_activity_led_oe(rx_oe),
      .collision_led(col_led),
      .link_good_led_in(lk_pin),
      .link_good_led_out(lk_out),
      .link_good_led_oe(lk_oe),
      .fiber_mode(fiber),
      .phy_address_strap(phy),
      .link_pulse_disable(lp),
      .straps_done(done)
   );

   // Strap resistors and LED buffers on the board.
   strap_board board_u (
      .rx_strap(rx_strap),
      .lk_strap(lk_strap),
      .rx_out(rx_out),
      .rx_oe(rx_oe),
      .lk_out(lk_out),
      .lk_oe(lk_oe),
      .rx_pin(rx_pin),
      .lk_pin(lk_pin)
   );

   ////////////////////////////////////////////////////////////////////////
   // Verdict and comparison helpers.

   // The one place where the run ends.
   task automatic close_out();
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Four-state compare, so an unknown output counts as a miss.
   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string what);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t: %s got %0h want %0h", $time, what, got, exp);
      end
   endtask

   // A wait that runs out is a mismatch and ends the run.
   task automatic timed_out(input string what);
      mismatches++;
      $display("[FAIL] %0t: timeout waiting for %s", $time, what);
      close_out();
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Avalon-MM master; every task starts just after a rising edge.

   // The request stands until waitrequest is sampled low at an edge.
   task automatic bus_write(input logic [3:0] a, input logic [31:0] d,
                            input logic [3:0] be);
      int n;
      n = 0;
      address <= a;
      writedata <= d;
      byteenable <= be;
      write <= 1'b1;
      @(posedge core_clk);
      while (waitrequest !== 1'b0 && n < WAIT_MAX) begin
         n++;
         @(posedge core_clk);
      end
      if (n >= WAIT_MAX) begin
         timed_out("write answer");
      end
      write <= 1'b0;
      @(posedge core_clk);
   endtask

   // Read data is taken at the same edge that shows waitrequest low.
   task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
      int n;
      n = 0;
      address <= a;
      read <= 1'b1;
      @(posedge core_clk);
      while (waitrequest !== 1'b0 && n < WAIT_MAX) begin
         n++;
         @(posedge core_clk);
      end
      if (n >= WAIT_MAX) begin
         timed_out("read answer");
      end
      d = readdata;
      read <= 1'b0;
      @(posedge core_clk);
   endtask

   // Read one register and compare it with the expected word.
   task automatic read_expect(input logic [3:0] a, input logic [31:0] exp,
                              input string what);
      logic [31:0] d;
      bus_read(a, d);
      check(d, exp, what);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios.

   // Reset with given strap levels; pins must stay released until the
   // capture, which lands a fixed number of edges after release.
   task automatic reset_capture(input logic [3:0] rx_s,
                                input logic [3:0] lk_s);
      int n;
      n = 0;
      rst <= 1'b1;
      rx_strap <= rx_s;
      lk_strap <= lk_s;
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      check(fiber, 4'h0, "fiber mode after reset");
      check(col_led, 4'h0, "collision after reset");
      check(waitrequest, 1'b1, "waitrequest after reset");
      while (done !== 1'b1 && n < WAIT_MAX) begin
         check({rx_oe, lk_oe}, 8'h00, "pins driven while sampling");
         n++;
         @(posedge core_clk);
      end
      if (n >= WAIT_MAX) begin
         timed_out("strap capture");
      end
      // Capture at edge SET, registered outputs one edge later.
      check(n, SET + 1, "capture time");
      check({rx_oe, lk_oe}, 8'hFF, "pins not driven after capture");
      check(fiber, rx_s, "fiber mode from strap");
      check(phy, lk_s[3:1], "address from link pins");
      check(lp, lk_s[0], "link pulse disable strap");
      read_expect(STRAP_RAW_OFS, (32'(lk_s[0]) << RAW_LP_BIT) |
                  32'(rx_s), "raw straps");
   endtask

   // Status levels reach the pins and the board one cycle later.
   task automatic status_drive(input logic [3:0] rx_a,
                               input logic [3:0] col,
                               input logic [3:0] lk_g);
      rx_activity <= rx_a;
      collision <= col;
      link_good <= lk_g;
      repeat (2) @(posedge core_clk);
      check(rx_out, rx_a, "receive activity pins");
      check(rx_pin, rx_a, "receive activity at board");
      check(col_led, col, "collision pins");
      check(lk_out, lk_g, "link pins");
      check(lk_pin, lk_g, "link at board");
   endtask

   // Flipped resistors and opposite pin levels must not touch the straps.
   task automatic strap_hold(input logic [3:0] rx_s, input logic [3:0] lk_s);
      rx_strap <= ~rx_s;
      lk_strap <= ~lk_s;
      status_drive(~rx_s, 4'h6, ~lk_s);
      check(fiber, rx_s, "fiber strap held");
      check(phy, lk_s[3:1], "address held");
      check(lp, lk_s[0], "link pulse strap held");
      read_expect(STRAP_RAW_OFS, (32'(lk_s[0]) << RAW_LP_BIT) |
                  32'(rx_s), "raw straps held");
   endtask

   // Control bits OR onto the straps; refused writes change nothing.
   task automatic control_regs(input logic [3:0] rx_s,
                               input logic [3:0] lk_s);
      logic [3:0] fib;
      logic [31:0] stat;
      fib = rx_s | 4'h5;
      stat = (32'h1 << ST_RUN_BIT) | (32'h1 << ST_LP_BIT) |
         (32'(lk_s[3:1]) << ST_PHY_LSB) | (32'(fib) << ST_FIBER_LSB);
      read_expect(FIBER_CTRL_OFS, 32'(FIBER_CTRL_RST), "fiber reset");
      bus_write(FIBER_CTRL_OFS, 32'h0000_0005, 4'hF);
      @(posedge core_clk);
      check(fiber, fib, "fiber strap or control");
      read_expect(FIBER_CTRL_OFS, 32'h0000_0005, "fiber readback");
      bus_write(FIBER_CTRL_OFS, 32'h0000_000A, 4'h0);
      read_expect(FIBER_CTRL_OFS, 32'h0000_0005, "masked write");
      bus_write(LINK_CTRL_OFS, 32'h0000_0001, 4'hF);
      @(posedge core_clk);
      check(lp, 1'b1, "link pulse disable by control");
      read_expect(STATUS_OFS, stat, "status word");
      bus_write(LINK_CTRL_OFS, 32'h0000_0000, 4'hF);
      @(posedge core_clk);
      check(lp, lk_s[0], "link pulses back on");
      read_expect(4'h2, 32'h0000_0000, "unmapped offset");
      // Left set so the next reset must clear it.
      bus_write(LINK_CTRL_OFS, 32'h0000_0001, 4'hF);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Run order; the second and third resets come in mid-run, the third
   // with both control bits set, so it shows they are cleared.
   initial begin
      reset_capture(4'h2, 4'h7);
      status_drive(4'h5, 4'h3, 4'hC);
      status_drive(4'hA, 4'hC, 4'h3);
      strap_hold(4'h2, 4'h7);
      reset_capture(4'h9, 4'hA);
      control_regs(4'h9, 4'hA);
      reset_capture(4'h0, 4'h0);
      close_out();
   end

   // A hang anywhere still reaches the verdict.
   initial begin
      repeat (RUN_MAX) @(posedge core_clk);
      timed_out("end of run");
   end
endmodule // strap_latch_and_led_status_bench

`default_nettype wire
